// *** hdl/coproc_transfer_interface.v ***
// Coprocessor transfer unit of the processor core: memory and register transfers.
// Assumes one synchronous clock, an Avalon-MM master for control, and coprocessors
// plus a memory manager answering on plain pins in the same clock domain.
//
// Overview of operation
// - Execute only when condition passes flags.
// - Core makes addresses; coprocessor moves data.
// - Offset is immediate times four, plus/minus.
// - Pre-index applies offset before use.
// - Write back modified base only if asked.
// - Successive words step up four bytes.
// - Low two address bits pass unaltered.
// - Program counter base reads as address+8.
// - Abort restores base, keeps other state.
// - Length bit passed to the coprocessor.
// - Move to PC sets flags from 31:28.
// - Register moves take one cycle unless busy.
// - Direction bit one means from coprocessor.
// - Opcode and register fields left uninterpreted.
// - Coprocessor number selects one of sixteen.
`include "coproc_xfer_defines.vh"
`default_nettype none

module coproc_transfer_interface #(
  parameter DATA_W = 32
) (
  input wire i_clk_sys,
  input wire i_rst,
  // Avalon-MM slave
  input wire [5:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [3:0] i_byteenable,
  input wire [DATA_W-1:0] i_writedata,
  output reg [DATA_W-1:0] o_readdata,
  output reg o_waitrequest,
  // Coprocessor side
  output reg o_cp_valid,
  output reg [DATA_W-1:0] o_cp_instr,
  output reg [3:0] o_coproc_number_field,
  output reg o_cp_len,
  output reg o_cp_from_coproc,
  output reg [DATA_W-1:0] o_cp_wdata,
  input wire i_cp_bounce,
  input wire i_cp_busy,
  input wire i_cp_last,
  input wire [DATA_W-1:0] i_cp_rdata,
  // Memory side
  output reg o_mem_req,
  output reg o_mem_write,
  output reg [DATA_W-1:0] o_mem_addr,
  input wire i_mem_abort,
  // Trap pulses
  output reg o_undef_trap,
  output reg o_data_abort
);

  localparam S_IDLE = 2'd0;
  localparam S_ISSUE = 2'd1;
  localparam S_MEM = 2'd2;

  reg [1:0] state;
  reg [DATA_W-1:0] instr;
  reg [DATA_W-1:0] base_register;
  reg [DATA_W-1:0] pc_addr;
  reg [3:0] current_status_register;
  reg [DATA_W-1:0] xfer_addr;
  reg [DATA_W-1:0] rd_data;
  reg [DATA_W-1:0] wr_data;
  reg [DATA_W-1:0] words;
  reg st_done;
  reg st_skipped;
  reg st_undef;
  reg st_abort;
  reg st_wb;

  // Condition check against N Z C V
  function cond_pass;
    input [3:0] cond;
    input [3:0] f;
    reg n, z, c, v;
    begin
      n = f[3];
      z = f[2];
      c = f[1];
      v = f[0];
      case (cond)
        4'h0: cond_pass = z;
        4'h1: cond_pass = !z;
        4'h2: cond_pass = c;
        4'h3: cond_pass = !c;
        4'h4: cond_pass = n;
        4'h5: cond_pass = !n;
        4'h6: cond_pass = v;
        4'h7: cond_pass = !v;
        4'h8: cond_pass = c & !z;
        4'h9: cond_pass = !c | z;
        4'ha: cond_pass = (n == v);
        4'hb: cond_pass = (n != v);
        4'hc: cond_pass = !z & (n == v);
        4'hd: cond_pass = z | (n != v);
        4'he: cond_pass = 1'b1;
        default: cond_pass = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Decode of the latched instruction
  wire is_mem = (instr[27:25] == `CLASS_MEM);
  wire is_reg = (instr[27:24] == `CLASS_REG) && instr[`F_REGMOVE];
  wire f_pre = instr[`F_PRE];
  wire f_up = instr[`F_UP];
  wire f_wb = instr[`F_WB];
  wire f_load = instr[`F_LOAD];
  wire [3:0] rn_idx = instr[`F_RN_HI:`F_RN_LO];
  wire [3:0] rd_idx = instr[`F_RD_HI:`F_RD_LO];

  // Address generation; the base value never aligns bits 1:0
  wire [DATA_W-1:0] base_val = (rn_idx == `PC_INDEX) ? pc_addr + `PC_AHEAD : base_register;
  wire [DATA_W-1:0] offset = {{(DATA_W-10){1'b0}}, instr[7:0], 2'b00};
  wire [DATA_W-1:0] modified = f_up ? base_val + offset : base_val - offset;
  wire [DATA_W-1:0] first_addr = f_pre ? modified : base_val;

  // Bus access strobes
  wire bus_req = (i_read | i_write) & o_waitrequest;
  wire wr_take = i_write & !o_waitrequest;
  wire start = wr_take && (i_address == `REG_CTRL) && i_byteenable[0] && i_writedata[0] && (state == S_IDLE);
  wire [5:0] status_word = {st_wb, st_abort, st_undef, st_skipped, st_done, state != S_IDLE};

  // Read mux, registered when the request is first seen
  reg [DATA_W-1:0] rd_mux;
  always @* begin
    case (i_address)
      `REG_INSTR: rd_mux = instr;
      `REG_BASE: rd_mux = base_register;
      `REG_PC: rd_mux = pc_addr;
      `REG_FLAGS: rd_mux = {current_status_register, 28'h0000000};
      `REG_STATUS: rd_mux = {26'h0, status_word};
      `REG_XFER_ADDR: rd_mux = xfer_addr;
      `REG_RD_DATA: rd_mux = rd_data;
      `REG_WR_DATA: rd_mux = wr_data;
      `REG_WORDS: rd_mux = words;
      default: rd_mux = `RST_WORD;
    endcase
  end

  // Slave handshake: one wait cycle, then the answer edge
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
      o_readdata <= `RST_WORD;
    end else if (bus_req) begin
      o_waitrequest <= 1'b0;
      o_readdata <= rd_mux;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // Control state, software registers and transfer sequencing
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= S_IDLE;
      instr <= `RST_WORD;
      base_register <= `RST_WORD;
      pc_addr <= `RST_WORD;
      current_status_register <= `RST_FLAGS;
      xfer_addr <= `RST_WORD;
      rd_data <= `RST_WORD;
      wr_data <= `RST_WORD;
      words <= `RST_WORD;
      st_done <= 1'b0;
      st_skipped <= 1'b0;
      st_undef <= 1'b0;
      st_abort <= 1'b0;
      st_wb <= 1'b0;
      o_cp_valid <= 1'b0;
      o_cp_instr <= `RST_WORD;
      o_coproc_number_field <= 4'h0;
      o_cp_len <= 1'b0;
      o_cp_from_coproc <= 1'b0;
      o_cp_wdata <= `RST_WORD;
      o_mem_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= `RST_WORD;
      o_undef_trap <= 1'b0;
      o_data_abort <= 1'b0;
    end else begin
      o_undef_trap <= 1'b0;
      o_data_abort <= 1'b0;
      // Software writes; state is frozen while a transfer runs
      if (wr_take && state == S_IDLE) begin
        case (i_address)
          `REG_INSTR: instr <= merge(instr, i_writedata, i_byteenable);
          `REG_BASE: base_register <= merge(base_register, i_writedata, i_byteenable);
          `REG_PC: pc_addr <= merge(pc_addr, i_writedata, i_byteenable);
          `REG_FLAGS: begin
            if (i_byteenable[3]) begin
              current_status_register <= i_writedata[`FLAG_HI:`FLAG_LO];
            end
          end
          `REG_WR_DATA: wr_data <= merge(wr_data, i_writedata, i_byteenable);
          default: ;
        endcase
      end
      case (state)
        S_IDLE: begin
          if (start) begin
            st_done <= 1'b0;
            st_skipped <= 1'b0;
            st_undef <= 1'b0;
            st_abort <= 1'b0;
            st_wb <= 1'b0;
            words <= `RST_WORD;
            if (!cond_pass(instr[`F_COND_HI:`F_COND_LO], current_status_register)) begin
              st_done <= 1'b1;
              st_skipped <= 1'b1;
            end else begin
              // Whole word handed over; opcode and register fields untouched
              o_cp_instr <= instr;
              o_coproc_number_field <= instr[`F_CPNUM_HI:`F_CPNUM_LO];
              o_cp_len <= is_mem & instr[`F_LEN];
              o_cp_from_coproc <= f_load;
              o_cp_wdata <= wr_data;
              o_cp_valid <= 1'b1;
              xfer_addr <= first_addr;
              state <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          if (i_cp_bounce) begin
            // Bounced: undefined-instruction trap, nothing else changes
            o_cp_valid <= 1'b0;
            o_undef_trap <= 1'b1;
            st_undef <= 1'b1;
            st_done <= 1'b1;
            state <= S_IDLE;
          end else if (!i_cp_busy) begin
            if (is_mem) begin
              // Accepted memory transfer: core drives addresses, coprocessor the data
              o_mem_req <= 1'b1;
              o_mem_write <= !f_load;
              o_mem_addr <= xfer_addr;
              state <= S_MEM;
            end else begin
              o_cp_valid <= 1'b0;
              if (is_reg && f_load) begin
                // Program counter as target only updates the flags
                if (rd_idx == `PC_INDEX) begin
                  current_status_register <= i_cp_rdata[`FLAG_HI:`FLAG_LO];
                end else begin
                  rd_data <= i_cp_rdata;
                end
              end
              st_done <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_MEM: begin
          if (i_mem_abort) begin
            // Base never written until the end, so it is already the original
            o_mem_req <= 1'b0;
            o_cp_valid <= 1'b0;
            o_data_abort <= 1'b1;
            st_abort <= 1'b1;
            st_done <= 1'b1;
            state <= S_IDLE;
          end else if (i_cp_last) begin
            // The coprocessor decides how many words move
            o_mem_req <= 1'b0;
            o_cp_valid <= 1'b0;
            words <= words + 32'h00000001;
            // Program counter base with write-back is not honoured
            if (f_wb && rn_idx != `PC_INDEX) begin
              base_register <= modified;
              st_wb <= 1'b1;
            end
            st_done <= 1'b1;
            state <= S_IDLE;
          end else begin
            words <= words + 32'h00000001;
            o_mem_addr <= o_mem_addr + `WORD_STEP;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // coproc_transfer_interface
`default_nettype wire

// *** pkg/coproc_xfer_defines.vh ***
// Offsets, field positions, reset values and status bit positions for the coprocessor transfer unit.
// Included by the unit's design file; holds definitions only.
`ifndef COPROC_XFER_DEFINES_VH
`define COPROC_XFER_DEFINES_VH

// Register byte offsets on the Avalon-MM slave
`define REG_CTRL 6'h00
`define REG_INSTR 6'h04
`define REG_BASE 6'h08
`define REG_PC 6'h0c
`define REG_FLAGS 6'h10
`define REG_STATUS 6'h14
`define REG_XFER_ADDR 6'h18
`define REG_RD_DATA 6'h1c
`define REG_WR_DATA 6'h20
`define REG_WORDS 6'h24

// Instruction field positions
`define F_COND_HI 31
`define F_COND_LO 28
`define F_PRE 24
`define F_UP 23
`define F_LEN 22
`define F_WB 21
`define F_LOAD 20
`define F_RN_HI 19
`define F_RN_LO 16
`define F_RD_HI 15
`define F_RD_LO 12
`define F_CPNUM_HI 11
`define F_CPNUM_LO 8
`define F_REGMOVE 4

// Class codes in bits 27:25 / 27:24
`define CLASS_MEM 3'h6
`define CLASS_REG 4'he

// Flag positions in the transferred word and the flags register
`define FLAG_HI 31
`define FLAG_LO 28

// Program counter register index and its read-ahead
`define PC_INDEX 4'hf
`define PC_AHEAD 32'h00000008
`define WORD_STEP 32'h00000004

// Reset values
`define RST_WORD 32'h00000000
`define RST_FLAGS 4'h0

// Status bit positions
`define ST_BUSY 0
`define ST_DONE 1
`define ST_SKIPPED 2
`define ST_UNDEF 3
`define ST_ABORT 4
`define ST_WB 5

`endif

// *** verification/coproc_transfer_checker_properties.sv ***
// Port checker for the coprocessor transfer unit, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module coproc_transfer_checker #(
  parameter DATA_W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic o_cp_valid,
  input wire logic [DATA_W-1:0] o_cp_instr,
  input wire logic [3:0] o_coproc_number_field,
  input wire logic o_cp_len,
  input wire logic o_cp_from_coproc,
  input wire logic i_cp_bounce,
  input wire logic i_cp_busy,
  input wire logic i_cp_last,
  input wire logic o_mem_req,
  input wire logic o_mem_write,
  input wire logic [DATA_W-1:0] o_mem_addr,
  input wire logic i_mem_abort,
  input wire logic o_undef_trap,
  input wire logic o_data_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Issue slot, not bounced; a stall here must not advance
  sequence s_issue;
    o_cp_valid && !o_mem_req && !i_cp_bounce;
  endsequence
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  a_one_wait: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus wait not one cycle");
  a_bounce_trap: assert property (o_cp_valid && !o_mem_req && i_cp_bounce |=> (!o_cp_valid and s_pulse(o_undef_trap)))
    else $error("bounce not trapped");
  a_busy_stall: assert property (s_issue ##0 i_cp_busy |=> o_cp_valid && !o_mem_req)
    else $error("busy wait ignored");
  a_move_single: assert property (s_issue ##0 (!i_cp_busy && o_cp_instr[27:24] == 4'he) |=> !o_cp_valid)
    else $error("move not one cycle");
  a_mem_start: assert property (s_issue ##0 (!i_cp_busy && o_cp_instr[27:25] == 3'h6) |=> o_mem_req)
    else $error("memory word not started");
  a_last_ends: assert property (o_mem_req && i_cp_last && !i_mem_abort |=> !o_mem_req && !o_cp_valid)
    else $error("last word not honoured");
  a_abort_trap: assert property (o_mem_req && i_mem_abort |=> (!o_mem_req and s_pulse(o_data_abort)))
    else $error("abort not trapped");
  a_word_step: assert property (o_mem_req && $past(o_mem_req) |-> o_mem_addr == $past(o_mem_addr) + 32'h4)
    else $error("word address step wrong");
  a_fields_out: assert property (o_cp_valid |-> o_cp_from_coproc == o_cp_instr[20] &&
    o_coproc_number_field == o_cp_instr[11:8] && o_cp_len == (o_cp_instr[27:25] == 3'h6 && o_cp_instr[22]) &&
    (!o_mem_req || o_mem_write == !o_cp_instr[20]))
    else $error("coprocessor fields wrong");
endmodule // coproc_transfer_checker
bind coproc_transfer_interface coproc_transfer_checker #(.DATA_W(DATA_W)) u_chk (
  .i_clk_sys, .i_rst, .i_read, .i_write, .o_waitrequest, .o_cp_valid, .o_cp_instr, .o_coproc_number_field,
  .o_cp_len, .o_cp_from_coproc, .i_cp_bounce, .i_cp_busy, .i_cp_last, .o_mem_req, .o_mem_write, .o_mem_addr,
  .i_mem_abort, .o_undef_trap, .o_data_abort);
`default_nettype wire

// *** verification/coproc_partner.sv ***
// Behavioural coprocessor and memory manager facing the transfer unit.
// Assumes the bench changes its knobs only while the unit is idle.
`default_nettype none
module coproc_partner #(
  parameter logic [3:0] MY_NUM = 4'h5
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [3:0] i_num,
  input wire logic i_len,
  input wire logic i_mem_req,
  input wire logic i_accept_mem,
  input wire logic [3:0] i_busy_n,
  input wire logic [3:0] i_nlong,
  input wire logic [3:0] i_abort_at,
  input wire logic [31:0] i_word,
  output logic o_bounce,
  output logic o_busy,
  output logic o_last,
  output logic o_abort,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bcnt;
  logic [3:0] wcnt;
  logic mine;
  // Answers only its own number; memory transfers refused unless told
  assign mine = i_valid && i_num == MY_NUM;
  assign o_bounce = mine && i_instr[27:25] == 3'h6 && !i_accept_mem;
  assign o_busy = mine && bcnt < i_busy_n;
  // Word count is ours to decide; long form from the knob
  assign o_last = i_mem_req && wcnt == (i_len ? i_nlong - 4'h1 : 4'h0);
  assign o_abort = i_mem_req && i_abort_at != 4'h0 && wcnt == i_abort_at - 4'h1;
  // Inverted copy when not selected, so stale data never passes
  assign o_rdata = mine ? i_word : ~i_word;
  // Stall and word counters, cleared between instructions
  always @(posedge i_clk_sys) begin
    if (i_rst || !i_valid) begin
      bcnt <= 4'h0;
      wcnt <= 4'h0;
    end else begin
      if (bcnt < i_busy_n) bcnt <= bcnt + 4'h1;
      if (i_mem_req) wcnt <= wcnt + 4'h1;
    end
  end
endmodule // coproc_partner
`default_nettype wire

// *** verification/coproc_transfer_interface_test.sv ***
// Self-checking bench for the coprocessor transfer unit over its register bus.
// Assumes the partner model on the coprocessor and memory pins.
`include "coproc_xfer_defines.vh"
`default_nettype none
module coproc_transfer_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CPN = 4'h5;
  localparam logic [15:0] PASS = 16'h66a9;
  logic i_clk_sys, i_rst, i_read, i_write, o_waitrequest, o_cp_valid, o_cp_len, o_cp_from_coproc, accept_mem;
  logic i_cp_bounce, i_cp_busy, i_cp_last, o_mem_req, o_mem_write, i_mem_abort, o_undef_trap, o_data_abort;
  logic [5:0] i_address;
  logic [3:0] i_byteenable, o_coproc_number_field, busy_n, nlong, abort_at;
  logic [31:0] i_writedata, o_readdata, o_cp_instr, i_cp_rdata, o_mem_addr, word, cp_wdata;
  int fail_count, cmp_count, k;
  coproc_transfer_interface #(.DATA_W(32)) DUT (.i_clk_sys, .i_rst, .i_address, .i_read, .i_write, .i_byteenable,
    .i_writedata, .o_readdata, .o_waitrequest, .o_cp_valid, .o_cp_instr, .o_coproc_number_field, .o_cp_len,
    .o_cp_from_coproc, .o_cp_wdata(cp_wdata), .i_cp_bounce, .i_cp_busy, .i_cp_last, .i_cp_rdata, .o_mem_req,
    .o_mem_write, .o_mem_addr, .i_mem_abort, .o_undef_trap, .o_data_abort);
  coproc_partner #(.MY_NUM(CPN)) u_cp (.i_clk_sys, .i_rst, .i_valid(o_cp_valid), .i_instr(o_cp_instr),
    .i_num(o_coproc_number_field), .i_len(o_cp_len), .i_mem_req(o_mem_req), .i_accept_mem(accept_mem),
    .i_busy_n(busy_n), .i_nlong(nlong), .i_abort_at(abort_at), .i_word(word), .o_bounce(i_cp_bounce),
    .o_busy(i_cp_busy), .o_last(i_cp_last), .o_abort(i_mem_abort), .o_rdata(i_cp_rdata));
  // Memory transfer word: {P,U,N,W,L}, base field, offset in words
  function automatic logic [31:0] mi(input logic [4:0] b, input logic [3:0] rn, input logic [7:0] imm);
    return {4'he, 3'h6, b, rn, 4'h3, CPN, imm};
  endfunction
  function automatic logic [31:0] ri(input logic [3:0] c, input logic l, input logic [3:0] rd);
    return {c, 4'he, 3'h2, l, 4'h1, rd, CPN, 3'h0, 1'b1, 4'h7};
  endfunction
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk_sys);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    // Waitrequest looked at on rising edges only; the answer edge also releases
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (o_waitrequest !== 1'b0) begin
      fail_count++;
      results();
    end
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp_count++;
    if ((q & m) !== e) begin
      fail_count++;
      $display("BAD reg %h expected %h seen %h", a, e, q & m);
    end
  endtask
  // Start an instruction and poll until the unit is idle again
  task automatic run(input logic [31:0] ins);
    logic [31:0] q;
    int n;
    wr(`REG_INSTR, ins);
    wr(`REG_CTRL, 32'h1);
    q = 32'h1;
    for (n = 0; n < 50 && q[`ST_BUSY] !== 1'b0; n++) bus(1'b0, `REG_STATUS, 32'h0, q);
    if (n == 50) begin
      fail_count++;
      results();
    end
  endtask
  // Free-running core clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Main sequence
  initial begin
    {i_rst, i_read, i_write, i_address, i_writedata, i_byteenable} = {1'b1, 40'h0, 4'hf};
    {accept_mem, busy_n, nlong, abort_at, word} = {1'b1, 4'h0, 4'h3, 4'h0, 32'ha5a51234};
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    chk(`REG_INSTR, `RST_WORD);
    wr(`REG_BASE, 32'h1000);
    run(mi(5'b11110, 4'h2, 8'h03));
    chk(`REG_XFER_ADDR, 32'h100c);
    chk(`REG_BASE, 32'h100c);
    chk(`REG_WORDS, 32'h3);
    chk(`REG_STATUS, 32'h22);
    wr(`REG_BASE, 32'h2001);
    run(mi(5'b00011, 4'h2, 8'h04));
    chk(`REG_XFER_ADDR, 32'h2001);
    chk(`REG_BASE, 32'h1ff1);
    wr(`REG_PC, 32'h400);
    wr(`REG_BASE, 32'h55);
    busy_n <= 4'h3;
    run(mi(5'b10000, 4'hf, 8'h02));
    chk(`REG_XFER_ADDR, 32'h400);
    chk(`REG_BASE, 32'h55);
    busy_n <= 4'h0;
    abort_at <= 4'h2;
    wr(`REG_BASE, 32'h3000);
    run(mi(5'b11110, 4'h1, 8'h01));
    chk(`REG_BASE, 32'h3000);
    chk(`REG_STATUS, 32'h10, 32'h10);
    abort_at <= 4'h0;
    wr(`REG_FLAGS, 32'h40000000);
    wr(`REG_WR_DATA, 32'h5a5a0f0f);
    for (k = 0; k < 16; k++) begin
      run(ri(k[3:0], 1'b0, 4'h1));
      chk(`REG_STATUS, {29'h0, ~PASS[k], 2'h0}, 32'h4);
    end
    // Source word of the last executed move still stands at the coprocessor
    cmp_count++;
    if (cp_wdata !== 32'h5a5a0f0f) begin
      fail_count++;
      $display("BAD cp_wdata expected %h seen %h", 32'h5a5a0f0f, cp_wdata);
    end
    run(ri(4'he, 1'b1, 4'hf));
    chk(`REG_FLAGS, 32'ha0000000, 32'hf0000000);
    chk(`REG_PC, 32'h400);
    run(ri(4'he, 1'b1, 4'h4));
    chk(`REG_RD_DATA, 32'ha5a51234);
    accept_mem <= 1'b0;
    run(mi(5'b11110, 4'h2, 8'h01));
    chk(`REG_STATUS, 32'h8, 32'h8);
    chk(`REG_BASE, 32'h3000);
    results();
  end
endmodule // coproc_transfer_interface_test
`default_nettype wire
